// file: shared/yuvp_params.svh
`ifndef YUVP_PARAMS_SVH
`define YUVP_PARAMS_SVH
`define YUVP_DT_NULL 6'h10
`define YUVP_DT_BLANK 6'h11
`define YUVP_DT_EMBED 6'h12
`define YUVP_DT_GEN_LAST 6'h17
`define YUVP_DT_Y420_8 6'h18
`define YUVP_DT_Y420_10 6'h19
`define YUVP_DT_Y420_LEG 6'h1a
`define YUVP_DT_RSVD_1B 6'h1b
`define YUVP_DT_Y420_8_CS 6'h1c
`define YUVP_DT_Y420_10_CS 6'h1d
`define YUVP_DT_Y422_8 6'h1e
`define YUVP_DT_Y422_10 6'h1f
`define YUVP_LSB_10 2'h0
`define YUVP_GRP_2 3'h2
`define YUVP_GRP_3 3'h3
`define YUVP_GRP_4 3'h4
`define YUVP_GRP_5 3'h5
`define YUVP_CNT_W 16
`endif

// file: shared/yuvp_pkg.sv
package yuvp_pkg;
   typedef logic [5:0] yuvp_dt_t;
   typedef logic [7:0] yuvp_byte_t;
   typedef enum logic [1:0]
   {
      YUVP_IDLE = 2'b00,
      YUVP_HEAD = 2'b01,
      YUVP_DATA = 2'b10
   } yuvp_state_e;
endpackage

// file: shared/yuvp_link_if.sv
`timescale 1ns/100ps
interface yuvp_link_if;
   logic sop;
   logic [5:0] dt;
   logic [15:0] wc;
   logic valid;
   logic ready;
   logic [7:0] data;
   logic last;
   modport tx (output sop, output dt, output wc, output valid, output data, output last,
      input ready);
   modport rx (input sop, input dt, input wc, input valid, input data, input last,
      output ready);
endinterface

// file: verilog/yuvp_skid.sv
`timescale 1ns/100ps
module yuvp_skid
   import yuvp_pkg::*;
(
   input wire logic i_clock,
   input wire logic i_rst,
   input wire logic i_valid,
   output logic o_ready,
   input wire logic [8:0] i_data,
   output logic o_valid,
   input wire logic i_ready,
   output logic [8:0] o_data
);
   // two entries, so a stall upstream one cycle late loses nothing
   logic [8:0] mem_q [0:1];
   logic wr_q;
   logic rd_q;
   logic [1:0] cnt_q;
   logic push;
   logic pop;
   assign o_ready = (cnt_q != 2'h2);
   assign o_valid = (cnt_q != 2'h0);
   assign push = i_valid && o_ready;
   assign pop = o_valid && i_ready;
   assign o_data = mem_q[rd_q];
   always_ff @(posedge i_clock)
   begin
      if (push)
      begin
         mem_q[wr_q] <= i_data;
      end
   end
   always_ff @(posedge i_clock)
   begin
      if (i_rst)
      begin
         wr_q <= 1'b0;
         rd_q <= 1'b0;
         cnt_q <= 2'h0;
      end
      else
      begin
         if (push)
         begin
            wr_q <= ~wr_q;
         end
         if (pop)
         begin
            rd_q <= ~rd_q;
         end
         cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
      end
   end
endmodule // yuvp_skid

// file: verilog/yuvp_tx.sv
// Operation
// - generic codes 10 null, 11 blank, 12 embedded
// - receiver drops null and blanking payloads
// - null means nothing; blanking marks gap lines
// - embedded lines sent with code 12
// - yuv codes 18 to 1f, 1b reserved
// - yuv420 frames carry even line count
// - legacy 420: odd U,Y,Y; even V,Y,Y
// - legacy 420 payload multiple of 3 bytes
// - bytes serialised lsb first
// - 420 8-bit: odd Y only, even UYVY
// - non-legacy 420 even line twice odd
// - 420 8-bit odd 2 bytes, even 4
// - 420 10-bit: odd Y only, even UYVY
// - 420 10-bit odd 5 bytes, even 10
// - 422 8-bit UYVY, multiple of 4 bytes
// - 422 10-bit UYVY, multiple of 5 bytes
// - reserved image codes never emitted
// - receiver accepts any generic layout
`timescale 1ns/100ps
`include "yuvp_params.svh"
module yuvp_tx
   import yuvp_pkg::*;
(
   input wire logic i_clock,
   input wire logic i_rst,
   // line request: type, length in groups, odd/even line
   input wire logic i_start,
   input wire logic [5:0] i_dt,
   input wire logic [15:0] i_groups,
   input wire logic i_odd_line,
   input wire logic i_frame_end,
   output logic o_busy,
   output logic o_refused,
   output logic o_frame_err,
   // sample input: one 10-bit sample per beat in wire order
   input wire logic i_smp_valid,
   input wire logic [9:0] i_smp,
   output logic o_smp_ready,
   yuvp_link_if.tx link
);
   yuvp_state_e state_q;
   yuvp_dt_t dt_q;
   logic odd_q;
   logic [15:0] left_q;
   logic [1:0] ph_q;
   logic [7:0] lsb_q;
   logic lines_q;
   logic hdr_v_q;
   logic head_go;
   logic buf_ready;
   logic ten_bit;
   logic [15:0] wc_d;
   logic allowed;
   logic byte_v;
   logic [7:0] byte_d;
   logic take;

   // bytes in one size group, per code and line parity
   function automatic logic [2:0] grp_bytes(input yuvp_dt_t dt, input logic odd);
      begin
         if (dt == `YUVP_DT_Y420_LEG)
            grp_bytes = `YUVP_GRP_3;
         else if (dt == `YUVP_DT_Y420_8 || dt == `YUVP_DT_Y420_8_CS)
            grp_bytes = odd ? `YUVP_GRP_2 : `YUVP_GRP_4;
         else if (dt == `YUVP_DT_Y420_10 || dt == `YUVP_DT_Y420_10_CS)
            grp_bytes = `YUVP_GRP_5; // even line sends two groups of five
         else if (dt == `YUVP_DT_Y422_8)
            grp_bytes = `YUVP_GRP_4;
         else if (dt == `YUVP_DT_Y422_10)
            grp_bytes = `YUVP_GRP_5;
         else
            grp_bytes = 3'h1; // generic: byte based
      end
   endfunction

   function automatic logic is_420(input yuvp_dt_t dt);
      is_420 = (dt >= `YUVP_DT_Y420_8) && (dt <= `YUVP_DT_Y420_10_CS) &&
         (dt != `YUVP_DT_RSVD_1B);
   endfunction

   // only defined generic and yuv codes pass; reserved ones are refused
   assign allowed = (i_dt <= `YUVP_DT_EMBED && i_dt >= `YUVP_DT_NULL) ||
      (i_dt >= `YUVP_DT_Y420_8 && i_dt != `YUVP_DT_RSVD_1B &&
       i_dt <= `YUVP_DT_Y422_10);
   assign wc_d = 16'(i_groups * {13'h0, grp_bytes(i_dt, i_odd_line)} *
      ((i_dt == `YUVP_DT_Y420_10 || i_dt == `YUVP_DT_Y420_10_CS) && !i_odd_line ?
      16'h2 : 16'h1));
   assign ten_bit = (dt_q == `YUVP_DT_Y420_10) || (dt_q == `YUVP_DT_Y420_10_CS) ||
      (dt_q == `YUVP_DT_Y422_10);
   assign o_busy = (state_q != YUVP_IDLE);
   // header waits for an empty buffer, else the far end reclassifies old bytes
   assign head_go = (state_q == YUVP_HEAD) && buf_ready && !link.valid;

   // 10-bit: four upper bytes then one byte of packed lsbs
   always_comb
   begin
      byte_v = 1'b0;
      byte_d = 8'h0;
      take = 1'b0;
      if (state_q == YUVP_DATA && buf_ready)
      begin
         if (ten_bit && hdr_v_q)
         begin
            byte_v = 1'b1;
            byte_d = lsb_q;
         end
         else if (i_smp_valid)
         begin
            take = 1'b1;
            byte_v = 1'b1;
            byte_d = ten_bit ? i_smp[9:2] : i_smp[7:0];
         end
      end
   end
   assign o_smp_ready = take;

   always_ff @(posedge i_clock)
   begin
      if (i_rst)
      begin
         state_q <= YUVP_IDLE;
         dt_q <= 6'h0;
         odd_q <= 1'b0;
         left_q <= 16'h0;
         o_refused <= 1'b0;
      end
      else
      begin
         o_refused <= 1'b0;
         case (state_q)
            YUVP_IDLE:
            begin
               if (i_start && allowed && wc_d != 16'h0)
               begin
                  dt_q <= i_dt;
                  odd_q <= i_odd_line;
                  left_q <= wc_d;
                  state_q <= YUVP_HEAD;
               end
               else if (i_start)
               begin
                  o_refused <= 1'b1;
               end
            end
            YUVP_HEAD:
            begin
               if (head_go)
               begin
                  state_q <= YUVP_DATA;
               end
            end
            YUVP_DATA:
            begin
               if (byte_v)
               begin
                  left_q <= left_q - 16'h1;
                  if (left_q == 16'h1)
                  begin
                     state_q <= YUVP_IDLE;
                  end
               end
            end
            default:
            begin
               state_q <= YUVP_IDLE;
            end
         endcase
      end
   end

   // lsb packing for 10-bit groups
   always_ff @(posedge i_clock)
   begin
      if (i_rst || state_q != YUVP_DATA)
      begin
         ph_q <= `YUVP_LSB_10;
         lsb_q <= 8'h0;
         hdr_v_q <= 1'b0;
      end
      else if (byte_v && ten_bit)
      begin
         if (hdr_v_q)
         begin
            hdr_v_q <= 1'b0;
            ph_q <= `YUVP_LSB_10;
         end
         else
         begin
            lsb_q[{ph_q, 1'b0} +: 2] <= i_smp[1:0];
            ph_q <= ph_q + 2'h1;
            hdr_v_q <= (ph_q == 2'h3);
         end
      end
   end

   // yuv420 line parity across a frame
   always_ff @(posedge i_clock)
   begin
      if (i_rst)
      begin
         lines_q <= 1'b0;
         o_frame_err <= 1'b0;
      end
      else if (i_frame_end)
      begin
         o_frame_err <= lines_q;
         lines_q <= 1'b0;
      end
      else
      begin
         o_frame_err <= 1'b0;
         if (head_go && is_420(dt_q))
         begin
            lines_q <= ~lines_q;
         end
      end
   end

   yuvp_skid u_buf
   (
      .i_clock(i_clock),
      .i_rst(i_rst),
      .i_valid(byte_v),
      .o_ready(buf_ready),
      .i_data({(left_q == 16'h1), byte_d}),
      .o_valid(link.valid),
      .i_ready(link.ready),
      .o_data({link.last, link.data})
   );

   // header fields held stable until the next HEAD state, which can begin before the previous packet's last bytes leave the buffer
   always_ff @(posedge i_clock)
   begin
      if (i_rst)
      begin
         link.sop <= 1'b0;
         link.dt <= 6'h0;
         link.wc <= 16'h0;
      end
      else
      begin
         link.sop <= head_go;
         if (state_q == YUVP_HEAD)
         begin
            link.dt <= dt_q;
            link.wc <= left_q;
         end
      end
   end
   // lsb-first serialisation happens in the lane layer on data[0] first
endmodule // yuvp_tx

// file: verilog/yuvp_rx.sv
`timescale 1ns/100ps
`include "yuvp_params.svh"
module yuvp_rx
   import yuvp_pkg::*;
(
   input wire logic i_clock,
   input wire logic i_rst,
   input wire logic i_out_ready,
   output logic o_valid,
   output logic [7:0] o_data,
   output logic [5:0] o_dt,
   output logic o_last,
   output logic o_embedded,
   output logic o_dt_err,
   yuvp_link_if.rx link
);
   logic keep_q;
   logic drop;
   function automatic logic rsvd(input yuvp_dt_t dt);
      rsvd = (dt > `YUVP_DT_EMBED && dt <= `YUVP_DT_GEN_LAST) || (dt == `YUVP_DT_RSVD_1B);
   endfunction
   assign drop = !keep_q;
   // dropped payload is drained at full rate so the link never stalls
   // accept exactly when the output stage loads, so a stall never repeats a byte
   assign link.ready = drop || !o_valid || i_out_ready;
   always_ff @(posedge i_clock)
   begin
      if (i_rst)
      begin
         keep_q <= 1'b0;
         o_dt <= 6'h0;
         o_embedded <= 1'b0;
         o_dt_err <= 1'b0;
      end
      else
      begin
         o_dt_err <= 1'b0;
         if (link.sop)
         begin
            o_dt <= link.dt;
            o_embedded <= (link.dt == `YUVP_DT_EMBED);
            keep_q <= !rsvd(link.dt) && link.dt != `YUVP_DT_NULL &&
               link.dt != `YUVP_DT_BLANK;
            o_dt_err <= rsvd(link.dt);
         end
      end
   end
   // any layout accepted for generic codes; embedded bytes passed through, null and blanking dropped
   always_ff @(posedge i_clock)
   begin
      if (i_rst)
      begin
         o_valid <= 1'b0;
         o_data <= 8'h0;
         o_last <= 1'b0;
      end
      else if (!o_valid || i_out_ready)
      begin
         o_valid <= link.valid && keep_q;
         o_data <= link.data;
         o_last <= link.last;
      end
   end
endmodule // yuvp_rx

// file: tb/yuvp_link_asserts.sv
`timescale 1ns/100ps
module yuvp_link_asserts
(
   input wire logic i_clock,
   input wire logic i_rst,
   input wire logic sop,
   input wire logic [5:0] dt,
   input wire logic [15:0] wc,
   input wire logic valid,
   input wire logic ready,
   input wire logic [7:0] data,
   input wire logic last
);
   logic [15:0] cnt_q;
   default clocking @(posedge i_clock); endclocking
   default disable iff (i_rst);
   // counts accepted bytes, so skid stalls cannot fake a length
   always_ff @(posedge i_clock)
   begin
      if (i_rst || (valid && ready && last))
      begin
         cnt_q <= 16'h0;
      end
      else if (valid && ready)
      begin
         cnt_q <= cnt_q + 16'h1;
      end
   end
   a_dt_no_rsvd: assert property (sop |-> !(dt inside {6'h1b, [6'h13:6'h17]}))
      else $error("reserved type sent");
   a_wc_legacy: assert property (sop && dt == 6'h1a |-> wc % 16'h3 == 16'h0)
      else $error("legacy length");
   a_wc_420_8: assert property (sop && dt inside {6'h18, 6'h1c} |-> !wc[0])
      else $error("420 8-bit length");
   a_wc_422_8: assert property (sop && dt == 6'h1e |-> wc[1:0] == 2'h0)
      else $error("422 8-bit length");
   a_wc_ten_bit: assert property (sop && dt inside {6'h19, 6'h1d, 6'h1f} |->
      wc % 16'h5 == 16'h0)
      else $error("10-bit length");
   a_wc_nonzero: assert property (sop |-> wc != 16'h0)
      else $error("empty packet");
   a_byte_count: assert property (valid && ready && last |-> cnt_q + 16'h1 == wc)
      else $error("byte count differs from wc");
   a_data_hold: assert property (valid && !ready |=> valid && $stable(data) && $stable(last))
      else $error("byte dropped in stall");
endmodule // yuvp_link_asserts

// file: tb/yuv_generic_payload_format_tb.sv
`timescale 1ns/100ps
module yuv_generic_payload_format_tb
   import yuvp_pkg::*;
;
   logic i_clock = 1'b0;
   logic i_rst = 1'b1;
   logic i_start = 1'b0, i_odd_line = 1'b0, i_frame_end = 1'b0;
   logic i_smp_valid = 1'b0, i_out_ready = 1'b1, stall = 1'b0;
   yuvp_dt_t i_dt = 6'h0;
   logic [15:0] i_groups = 16'h0;
   logic [9:0] i_smp = 10'h0;
   logic o_busy, o_refused, o_frame_err, o_smp_ready, o_valid, o_last, o_embedded, o_dt_err;
   yuvp_byte_t o_data;
   yuvp_dt_t o_dt, rx_dt;
   logic rx_last, rx_emb;
   logic [15:0] wc_seen;
   yuvp_byte_t rx_q[$];
   int fail_count = 0, cmp_count = 0, cyc = 0, n_ref = 0, n_ferr = 0, n_last = 0, n_derr = 0;
   logic [15:0] tab[15] = '{16'h1e30, 16'h1f20, 16'h1a21, 16'h1a20, 16'h1821, 16'h1820,
      16'h1911, 16'h1910, 16'h1c11, 16'h1c10, 16'h1d11, 16'h1d10, 16'h1250, 16'h1030, 16'h1130};
   `define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin fail_count++; \
      $display("[FAIL] t=%0t got %h exp %h", $time, a, b); end end

   initial forever #25 i_clock = ~i_clock;

   yuvp_link_if link();
   yuvp_tx u_yuvp_tx (.i_clock(i_clock), .i_rst(i_rst), .i_start(i_start), .i_dt(i_dt),
      .i_groups(i_groups), .i_odd_line(i_odd_line), .i_frame_end(i_frame_end),
      .o_busy(o_busy), .o_refused(o_refused), .o_frame_err(o_frame_err),
      .i_smp_valid(i_smp_valid), .i_smp(i_smp), .o_smp_ready(o_smp_ready), .link(link.tx));
   yuvp_rx u_yuvp_rx (.i_clock(i_clock), .i_rst(i_rst), .i_out_ready(i_out_ready),
      .o_valid(o_valid), .o_data(o_data), .o_dt(o_dt), .o_last(o_last),
      .o_embedded(o_embedded), .o_dt_err(o_dt_err), .link(link.rx));
   yuvp_link_asserts u_yuvp_link_asserts (.i_clock(i_clock), .i_rst(i_rst), .sop(link.sop),
      .dt(link.dt), .wc(link.wc), .valid(link.valid), .ready(link.ready),
      .data(link.data), .last(link.last));

   function automatic int grp(yuvp_dt_t d, logic odd);
      case (d)
         6'h18, 6'h1c: grp = odd ? 2 : 4;
         6'h19, 6'h1d: grp = odd ? 5 : 10;
         6'h1a: grp = 3;
         6'h1e: grp = 4;
         6'h1f: grp = 5;
         default: grp = 1;
      endcase
   endfunction

   function automatic logic [9:0] sv(int k);
      sv = 10'(k * 37 + 5);
   endfunction

   // ten-bit packing: four upper bytes, then the low bit pairs
   function automatic yuvp_byte_t eb(logic ten, int i);
      int j;
      logic [9:0] s0, s1, s2, s3, sw;
      j = (i / 5) * 4;
      s0 = sv(j);
      s1 = sv(j + 1);
      s2 = sv(j + 2);
      s3 = sv(j + 3);
      sw = sv(ten ? j + i % 5 : i);
      if (!ten)
         eb = sw[7:0];
      else if (i % 5 < 4)
         eb = sw[9:2];
      else
         eb = {s3[1:0], s2[1:0], s1[1:0], s0[1:0]};
   endfunction

   always @(posedge i_clock)
   begin
      cyc++;
      i_out_ready <= !stall || cyc[1];
      if (o_refused)
         n_ref++;
      if (o_frame_err)
         n_ferr++;
      if (o_dt_err)
         n_derr++;
      if (link.sop)
         wc_seen = link.wc;
      if (o_valid && i_out_ready)
      begin
         rx_q.push_back(o_data);
         rx_last = o_last;
         rx_dt = o_dt;
         rx_emb = o_embedded;
         n_last += int'(o_last);
      end
      if (cyc == 20000)
      begin
         fail_count++;
         end_sim();
      end
   end

   task automatic line(input yuvp_dt_t d, input int g, input logic odd);
      int n, wc, k;
      logic ok, b, ten, rf, emit;
      n = 0;
      n_last = 0;
      rx_q.delete();
      ten = d inside {6'h19, 6'h1d, 6'h1f};
      rf = g == 0 || d inside {6'h1b, [6'h13:6'h17]};
      emit = !(d inside {6'h10, 6'h11});
      wc = g * grp(d, odd);
      i_start <= 1'b1;
      i_dt <= d;
      i_groups <= 16'(g);
      i_odd_line <= odd;
      i_smp_valid <= 1'b1;
      i_smp <= sv(0);
      @(posedge i_clock);
      i_start <= 1'b0;
      forever
      begin
         @(negedge i_clock);
         ok = o_smp_ready;
         b = o_busy;
         @(posedge i_clock);
         if (ok)
         begin
            n++;
            i_smp <= sv(n);
         end
         if (!b || n > 300)
            break;
      end
      i_smp_valid <= 1'b0;
      for (k = 0; k < 80 && rx_q.size() < (emit && !rf ? wc : 0); k++)
         @(posedge i_clock);
      repeat (3) @(posedge i_clock);
      if (rf)
      begin
         `CHK(rx_q.size(), 0)
      end
      else
      begin
         `CHK(wc_seen, 16'(wc))
         `CHK(rx_q.size(), emit ? wc : 0)
      end
      if (!rf && emit)
      begin
         `CHK(n, ten ? wc * 4 / 5 : wc)
         for (k = 0; k < rx_q.size(); k++)
            `CHK(rx_q[k], eb(ten, k))
         `CHK(rx_dt, d)
         `CHK(rx_emb, d == 6'h12)
         `CHK({rx_last, n_last}, {1'b1, 32'd1})
      end
   endtask

   task automatic fend(input int exp);
      i_frame_end <= 1'b1;
      @(posedge i_clock);
      i_frame_end <= 1'b0;
      repeat (3) @(posedge i_clock);
      `CHK(n_ferr, exp)
   endtask

   task automatic end_sim();
      $display("compares %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0)
      begin
         $display("Run complete: PASS");
      end
      else
      begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   initial
   begin
      repeat (2) @(posedge i_clock);
      i_rst <= 1'b0;
      @(posedge i_clock);
      // every defined code, odd and even lines for the 420 codes, back to back
      for (int k = 0; k < 15; k++)
         line(tab[k][13:8], int'(tab[k][7:4]), tab[k][0]);
      $display("test formats done");
      fend(0);
      line(6'h18, 3, 1);
      fend(1);
      $display("test frame parity done");
      line(6'h1b, 2, 0);
      line(6'h13, 2, 0);
      line(6'h1e, 0, 0);
      `CHK(n_ref, 3)
      `CHK(n_derr, 0)
      $display("test refusals done");
      stall = 1'b1;
      line(6'h1f, 6, 0);
      line(6'h1e, 5, 1);
      stall = 1'b0;
      $display("test stall done");
      end_sim();
   end
endmodule // yuv_generic_payload_format_tb
